// file: core/rg_pkg.sv
package rg_pkg;

	// ****************************************
	// clock and time base
	// ****************************************
	localparam int CLOCK_HZ      = 50_000_000;
	localparam int MS_PER_S      = 1000;
	localparam int CYCLES_PER_MS = CLOCK_HZ / MS_PER_S;
	localparam int MS_W          = 16;

	// ****************************************
	// release waits in ms, indexed by the 3-bit select
	// ****************************************
	localparam int SEL_W = 3;
	localparam logic [MS_W-1:0] ORD_WAIT_MS [0:7] = '{
		16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0010, 16'h0018, 16'h0020, 16'h002d};
	localparam logic [MS_W-1:0] NET_WAIT_MS [0:7] = '{
		16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0006, 16'h0008, 16'h000a};

	// ****************************************
	// hold timers in ms (plain defaults)
	// ****************************************
	localparam int STUCK_MS  = 500;
	localparam int ACK_MS    = 2000;
	localparam int LINGER_MS = 100;

	// ****************************************
	// register map (byte addresses) and fields
	// ****************************************
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] CONTROL_ADDR = 4'h0;
	localparam logic [ADDR_W-1:0] DELAY_ADDR   = 4'h4;
	localparam logic [ADDR_W-1:0] STATUS_ADDR  = 4'h8;

	localparam int CTL_KEEP_AWAKE = 0;
	localparam int CTL_TX_LEVEL   = 1;
	localparam int DLY_ORD_LSB    = 0;
	localparam int DLY_NET_LSB    = 4;
	localparam int ST_LINE        = 0;
	localparam int ST_VALID       = 1;
	localparam int ST_FORCE       = 2;
	localparam int ST_EXT_LOW     = 3;
	localparam int ST_STUCK_RUN   = 4;
	localparam int ST_ACK_RUN     = 5;
	localparam int ST_LINGER_RUN  = 6;
	localparam int ST_NET_WAKE    = 7;

	localparam logic [SEL_W-1:0] ORD_SEL_RESET = 3'h0;
	localparam logic [SEL_W-1:0] NET_SEL_RESET = 3'h0;

	// ****************************************
	// release sequence
	// ****************************************
	typedef enum logic [1:0] {
		RG_HOLD     = 2'b00,
		RG_WAIT     = 2'b01,
		RG_RELEASED = 2'b11
	} rg_state_type;

endpackage : rg_pkg

// file: core/rg_timer.sv
`timescale 1ns/10ps
module rg_timer
	import rg_pkg::*;
(
	input  wire logic            clock_in,
	input  wire logic            reset_in,
	input  wire logic            tick_in,
	input  wire logic            start_in,
	input  wire logic            stop_in,
	input  wire logic [MS_W-1:0] load_in,
	output logic                 running_out,
	output logic                 expired_out
);

	logic [MS_W-1:0] count;

	// start wins over stop; counts whole ms ticks down to zero
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			count       <= '0;
			running_out <= 1'b0;
			expired_out <= 1'b0;
		end else if (start_in) begin
			count       <= load_in;
			running_out <= 1'b1;
			expired_out <= 1'b0;
		end else if (stop_in) begin
			count       <= '0;
			running_out <= 1'b0;
			expired_out <= 1'b0;
		end else if (running_out && tick_in) begin
			if (count <= MS_W'(1)) begin
				count       <= '0;
				running_out <= 1'b0;
				expired_out <= 1'b1;
			end else begin
				count <= count - MS_W'(1);
			end
		end else begin
			expired_out <= 1'b0;
		end
	end

endmodule : rg_timer

// file: core/rg_reset_gen.sv
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
// What this block does
// RQ1: after power-up hold the reset line low until supply passes rising trip.
// RQ2: release after delay; network wait if woken by network, else ordinary.
// RQ3: supply below falling trip asserts reset and marks supply invalid.
// RQ4: reset line level always readable as a status bit.
// RQ5: ordinary release wait chosen by 3-bit field, 1 ms to 45 ms.
// RQ6: network release wait chosen by separate 3-bit field, 1 ms to 10 ms.
// RQ7: reset line is open-drain; only ever pulled low.
// RQ8: when not pulling, sample the line and detect external low.
// RQ9: transmit level bit forced set while the line is low.
// RQ10: keep-awake bit forced clear while the line is low.
// RQ11: bus line driver disabled while the line is low.
// RQ12: line assertion starts stuck timer forcing active; expiry ends that force.
// RQ13: line deassertion restarts init-ack timer forcing active.
// RQ14: init-ack timer reset by power-hold low or keep-awake set.
// RQ15: init-ack expiry without acknowledgement ends its force.
// RQ16: host pulls power-hold low or sets keep-awake within init-ack window.
// RQ17: power-hold release or keep-awake clear starts linger timer forcing active.
// RQ18: power-hold ignored while supply invalid and reset asserted.
// RQ19: transmit level bit clear pulls bus low, ORed with transmit pin.
// RQ20: active force is OR of timers, power-hold, keep-awake and other wakes.
module rg_reset_gen
	import rg_pkg::*;
#(
	parameter int CYCLES_PER_MS_P = CYCLES_PER_MS,
	parameter int STUCK_MS_P      = STUCK_MS,
	parameter int ACK_MS_P        = ACK_MS,
	parameter int LINGER_MS_P     = LINGER_MS
) (
	input  wire logic              clock_in,
	input  wire logic              reset_in,
	// avalon-mm slave
	input  wire logic [ADDR_W-1:0] address_in,
	input  wire logic              read_in,
	input  wire logic              write_in,
	input  wire logic [31:0]       writedata_in,
	output logic      [31:0]       readdata_out,
	output logic                   waitrequest_out,
	// supply comparators
	input  wire logic              supply_above_rise_in,
	input  wire logic              supply_below_fall_in,
	input  wire logic              net_wake_in,
	// open-drain reset line
	input  wire logic              reset_line_in,
	output logic                   reset_line_out,
	output logic                   reset_line_oe_out,
	// power hold, active low
	input  wire logic              power_hold_n_in,
	input  wire logic              other_wake_in,
	// bus transmitter
	input  wire logic              tx_pin_in,
	output logic                   bus_drive_low_out,
	output logic                   bus_driver_enable_out,
	output logic                   active_force_out
);

	// ****************************************
	// declarations
	// ****************************************
	rg_state_type     state;
	rg_state_type     next_state;
	logic             supply_valid;
	logic             line_low;
	logic             line_low_q;
	logic             ext_low;
	logic             keep_awake;
	logic             tx_level;
	logic [SEL_W-1:0] ord_sel;
	logic [SEL_W-1:0] net_sel;
	logic             net_wake;
	logic [MS_W-1:0]  wait_ms;
	logic [31:0]      pre_count;
	logic             ms_tick;
	logic             hold_ok;
	logic             hold_ok_q;
	logic             keep_awake_q;
	logic             line_fall;
	logic             line_rise;
	logic             wr_en;
	logic             wait_run;
	logic             wait_done;
	logic             stuck_run;
	logic             ack_run;
	logic             linger_run;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [MS_W-1:0] wait_for(input logic net, input logic [SEL_W-1:0] o,
		input logic [SEL_W-1:0] n);
		wait_for = net ? NET_WAIT_MS[n] : ORD_WAIT_MS[o]; // [RQ2]
	endfunction : wait_for

	assign line_low  = ~reset_line_in;
	assign line_fall = line_low & ~line_low_q;
	assign line_rise = ~line_low & line_low_q;
	assign hold_ok   = ~power_hold_n_in & supply_valid; // [RQ18]
	assign wr_en     = write_in & ~waitrequest_out;
	assign wait_ms   = wait_for(net_wake, ord_sel, net_sel);

	// ****************************************
	// millisecond tick
	// ****************************************
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			pre_count <= '0;
			ms_tick   <= 1'b0;
		end else if (pre_count >= 32'(CYCLES_PER_MS_P - 1)) begin
			pre_count <= '0;
			ms_tick   <= 1'b1;
		end else begin
			pre_count <= pre_count + 32'h1;
			ms_tick   <= 1'b0;
		end
	end

	// ****************************************
	// supply validity
	// ****************************************
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			supply_valid <= 1'b0; // [RQ1]
		end else if (supply_below_fall_in) begin
			supply_valid <= 1'b0; // [RQ3]
		end else if (supply_above_rise_in) begin
			supply_valid <= 1'b1;
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			net_wake <= 1'b0;
		end else if (state == RG_HOLD) begin
			net_wake <= net_wake_in; // [RQ2]
		end
	end

	// ****************************************
	// release sequence
	// ****************************************
	always_comb begin
		next_state = state;
		case (state)
			RG_HOLD: begin
				if (supply_valid) begin
					next_state = RG_WAIT; // [RQ1]
				end
			end
			RG_WAIT: begin
				if (!supply_valid) begin
					next_state = RG_HOLD;
				end else if (wait_done) begin
					next_state = RG_RELEASED; // [RQ2]
				end
			end
			RG_RELEASED: begin
				if (!supply_valid) begin
					next_state = RG_HOLD; // [RQ3]
				end
			end
			default: begin
				next_state = RG_HOLD;
			end
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			state             <= RG_HOLD;
			reset_line_oe_out <= 1'b1;
			reset_line_out    <= 1'b0;
		end else begin
			state             <= next_state;
			reset_line_oe_out <= (next_state != RG_RELEASED); // [RQ1] [RQ3]
			reset_line_out    <= 1'b0; // [RQ7]
		end
	end

	// ****************************************
	// line sampling
	// ****************************************
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			line_low_q <= 1'b1;
			ext_low    <= 1'b0;
		end else begin
			line_low_q <= line_low;
			ext_low    <= line_low & ~reset_line_oe_out; // [RQ8]
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			keep_awake <= 1'b0;
			tx_level   <= 1'b1;
			ord_sel    <= ORD_SEL_RESET;
			net_sel    <= NET_SEL_RESET;
		end else begin
			if (wr_en && address_in == CONTROL_ADDR) begin
				keep_awake <= writedata_in[CTL_KEEP_AWAKE];
				tx_level   <= writedata_in[CTL_TX_LEVEL];
			end
			if (wr_en && address_in == DELAY_ADDR) begin
				ord_sel <= writedata_in[DLY_ORD_LSB +: SEL_W]; // [RQ5]
				net_sel <= writedata_in[DLY_NET_LSB +: SEL_W]; // [RQ6]
			end
			if (line_low) begin
				tx_level   <= 1'b1; // [RQ9]
				keep_awake <= 1'b0; // [RQ10]
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			waitrequest_out <= 1'b1;
			readdata_out    <= '0;
		end else begin
			waitrequest_out <= ~((read_in | write_in) & waitrequest_out);
			if (read_in && waitrequest_out) begin
				readdata_out <= '0;
				case (address_in)
					CONTROL_ADDR: begin
						readdata_out[CTL_KEEP_AWAKE] <= keep_awake;
						readdata_out[CTL_TX_LEVEL]   <= tx_level;
					end
					DELAY_ADDR: begin
						readdata_out[DLY_ORD_LSB +: SEL_W] <= ord_sel;
						readdata_out[DLY_NET_LSB +: SEL_W] <= net_sel;
					end
					STATUS_ADDR: begin
						readdata_out[ST_LINE]       <= reset_line_in; // [RQ4]
						readdata_out[ST_VALID]      <= supply_valid;
						readdata_out[ST_FORCE]      <= active_force_out;
						readdata_out[ST_EXT_LOW]    <= ext_low;
						readdata_out[ST_STUCK_RUN]  <= stuck_run;
						readdata_out[ST_ACK_RUN]    <= ack_run;
						readdata_out[ST_LINGER_RUN] <= linger_run;
						readdata_out[ST_NET_WAKE]   <= net_wake;
					end
					default: begin
						readdata_out <= '0;
					end
				endcase
			end
		end
	end

	// ****************************************
	// timers
	// ****************************************
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			hold_ok_q    <= 1'b0;
			keep_awake_q <= 1'b0;
		end else begin
			hold_ok_q    <= hold_ok;
			keep_awake_q <= keep_awake;
		end
	end

	rg_timer u_wait (
		.clock_in    (clock_in),
		.reset_in    (reset_in),
		.tick_in     (ms_tick),
		.start_in    (state == RG_HOLD && supply_valid),
		.stop_in     (state != RG_WAIT && !(state == RG_HOLD && supply_valid)),
		.load_in     (MS_W'(wait_ms + MS_W'(1))), // extra tick: a partial first ms never shortens the wait
		.running_out (wait_run),
		.expired_out (wait_done)
	);

	rg_timer u_stuck (
		.clock_in    (clock_in),
		.reset_in    (reset_in),
		.tick_in     (ms_tick),
		.start_in    (line_fall), // [RQ12]
		.stop_in     (line_rise),
		.load_in     (MS_W'(STUCK_MS_P)),
		.running_out (stuck_run),
		.expired_out ()
	);

	rg_timer u_ack (
		.clock_in    (clock_in),
		.reset_in    (reset_in),
		.tick_in     (ms_tick),
		.start_in    (line_rise), // [RQ13]
		.stop_in     (hold_ok | keep_awake | line_low), // [RQ14]
		.load_in     (MS_W'(ACK_MS_P)),
		.running_out (ack_run), // [RQ15]
		.expired_out ()
	);

	rg_timer u_linger (
		.clock_in    (clock_in),
		.reset_in    (reset_in),
		.tick_in     (ms_tick),
		.start_in    ((hold_ok_q & ~hold_ok) | (keep_awake_q & ~keep_awake)), // [RQ17]
		.stop_in     (1'b0),
		.load_in     (MS_W'(LINGER_MS_P)),
		.running_out (linger_run),
		.expired_out ()
	);

	// ****************************************
	// outputs
	// ****************************************
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			active_force_out      <= 1'b1;
			bus_driver_enable_out <= 1'b0;
			bus_drive_low_out     <= 1'b0;
		end else begin
			active_force_out <= stuck_run | ack_run | linger_run | hold_ok
				| keep_awake | other_wake_in | line_fall | line_rise; // [RQ20]
			bus_driver_enable_out <= ~line_low; // [RQ11]
			bus_drive_low_out     <= ~line_low & (~tx_level | ~tx_pin_in); // [RQ19] [RQ11]
		end
	end

endmodule : rg_reset_gen

// file: verification/rg_props.sv
`timescale 1ns/10ps
module rg_props (
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic read_in,
	input wire logic write_in,
	input wire logic waitrequest_out,
	input wire logic supply_below_fall_in,
	input wire logic reset_line_in,
	input wire logic reset_line_out,
	input wire logic reset_line_oe_out,
	input wire logic other_wake_in,
	input wire logic bus_driver_enable_out,
	input wire logic active_force_out
);
	// ********
	// rules seen at the ports
	// ********
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (reset_in);
	property p_out_low; reset_line_out == 1'b0; endproperty
	a_out_low: assert property (p_out_low) else $error("line driven high");
	property p_fall_assert; supply_below_fall_in |-> ##[1:3] reset_line_oe_out; endproperty
	a_fall_assert: assert property (p_fall_assert) else $error("no assert on fall");
	property p_fall_keep; supply_below_fall_in && reset_line_oe_out |=> reset_line_oe_out; endproperty
	a_fall_keep: assert property (p_fall_keep) else $error("released while invalid");
	property p_drv_off; !reset_line_in [*3] |-> !bus_driver_enable_out; endproperty
	a_drv_off: assert property (p_drv_off) else $error("driver on with line low");
	property p_stuck_force; $fell(reset_line_in) |-> ##[0:3] active_force_out; endproperty
	a_stuck_force: assert property (p_stuck_force) else $error("no force on line low");
	property p_ack_force; $rose(reset_line_in) |-> ##[0:3] active_force_out; endproperty
	a_ack_force: assert property (p_ack_force) else $error("no force on line high");
	property p_other; other_wake_in [*3] |-> active_force_out; endproperty
	a_other: assert property (p_other) else $error("wake event not forcing");
	property p_wait_ans; (read_in || write_in) && waitrequest_out |=> !waitrequest_out; endproperty
	a_wait_ans: assert property (p_wait_ans) else $error("bus answer late");
	property p_wait_one; !waitrequest_out |=> waitrequest_out; endproperty
	a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
	c_release: cover property ($rose(reset_line_in));
	c_ext: cover property (!reset_line_in && !reset_line_oe_out);
	c_read: cover property (read_in && !waitrequest_out);
endmodule : rg_props

bind rg_reset_gen rg_props u_props (.clock_in(clock_in), .reset_in(reset_in), .read_in(read_in),
	.write_in(write_in), .waitrequest_out(waitrequest_out), .supply_below_fall_in(supply_below_fall_in),
	.reset_line_in(reset_line_in), .reset_line_out(reset_line_out), .reset_line_oe_out(reset_line_oe_out),
	.other_wake_in(other_wake_in), .bus_driver_enable_out(bus_driver_enable_out),
	.active_force_out(active_force_out));

// file: verification/rg_host.sv
`timescale 1ns/10ps
module rg_host (
	input  wire logic        clock_in,
	input  wire logic        oe_in,
	input  wire logic        pull_in,
	input  wire logic        en_in,
	input  wire logic [15:0] len_in,
	output logic             line_out,
	output logic             hold_n_out
);
	// ********
	// wire-or reset line with pull-up, host power hold
	// ********
	assign line_out = !(oe_in || pull_in);
	initial begin
		hold_n_out = 1'b1;
		forever begin
			@(posedge line_out);
			if (en_in) begin
				repeat (10) @(posedge clock_in);
				hold_n_out <= 1'b0;
				repeat (len_in) @(posedge clock_in);
				hold_n_out <= 1'b1;
			end
		end
	end
endmodule : rg_host

// file: verification/rg_reset_gen_tb_top.sv
`timescale 1ns/10ps
module rg_reset_gen_tb_top;
	import rg_pkg::*;
	localparam int CMS = 10;
	logic              clock_in, reset_in, rd, wr, rise, fall, net, ow, txp, pull, en;
	logic              line, hold_n, oe, lo, den, frc, wait_r;
	logic [3:0]        addr;
	logic [15:0]       len;
	logic [31:0]       wdata, rdata, q;
	int unsigned       seed, r;
	int                error_cnt, total_checks, ms, n, sel;

	rg_reset_gen #(.CYCLES_PER_MS_P(CMS), .STUCK_MS_P(5), .ACK_MS_P(5), .LINGER_MS_P(5)) dut (
		.clock_in(clock_in), .reset_in(reset_in), .address_in(addr), .read_in(rd), .write_in(wr),
		.writedata_in(wdata), .readdata_out(rdata), .waitrequest_out(wait_r), .supply_above_rise_in(rise),
		.supply_below_fall_in(fall), .net_wake_in(net), .reset_line_in(line), .reset_line_out(),
		.reset_line_oe_out(oe), .power_hold_n_in(hold_n), .other_wake_in(ow), .tx_pin_in(txp),
		.bus_drive_low_out(lo), .bus_driver_enable_out(den), .active_force_out(frc));
	rg_host host (.clock_in(clock_in), .oe_in(oe), .pull_in(pull), .en_in(en), .len_in(len),
		.line_out(line), .hold_n_out(hold_n));

	// ********
	// helpers
	// ********
	function automatic int unsigned xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task cyc(input int c);
		repeat (c) @(posedge clock_in);
	endtask : cyc
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clock_in);
		addr <= a;
		wr <= w;
		rd <= !w;
		wdata <= d;
		do begin
			@(posedge clock_in);
		end while (wait_r !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	task end_of_test();
		if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test

	initial begin
		clock_in = 1'b0;
		forever #10 clock_in = ~clock_in;
	end
	initial begin
		repeat (20000) @(posedge clock_in);
		error_cnt++;
		end_of_test();
	end

	// ********
	// scenarios
	// ********
	initial begin
		{rd, wr, rise, fall, net, ow, txp, pull, en} = '0;
		reset_in = 1'b1;
		addr = 4'h0;
		wdata = 32'h0;
		len = 16'h001e;
		seed = 43;
		error_cnt = 0;
		total_checks = 0;
		cyc(16);
		reset_in <= 1'b0;
		bus(0, CONTROL_ADDR, 0);
		chk("ctl_reset", 32'h2, q);
		chk("oe_hold", 1, oe);
		for (int k = 0; k < 16; k++) begin
			sel = k % 8;
			net <= k[3];
			fall <= 1'b1;
			rise <= 1'b0;
			cyc(4);
			chk("oe_fall", 1, oe);
			fall <= 1'b0;
			bus(1, DELAY_ADDR, {25'h0, 3'(7 - sel), 1'b0, 3'(sel)});
			bus(0, DELAY_ADDR, 0);
			chk("delay", {25'h0, 3'(7 - sel), 1'b0, 3'(sel)}, q);
			chk("oe_hold", 1, oe);
			ms = k[3] ? int'(NET_WAIT_MS[7 - sel]) : int'(ORD_WAIT_MS[sel]);
			rise <= 1'b1;
			n = 0;
			while (oe === 1'b1 && n < 700) begin
				@(posedge clock_in);
				n++;
			end
			chk("release", 1, n >= ms * CMS && n <= ms * CMS + 15);
		end
		cyc(2);
		chk("drv_on", 1, den);
		for (int k = 0; k < 8; k++) begin
			r = xs();
			txp <= r[0];
			bus(1, CONTROL_ADDR, {30'h0, r[1], 1'b0});
			cyc(3);
			chk("drive_low", !r[1] | !r[0], lo);
		end
		cyc(100);
		chk("force", 0, frc);
		bus(0, 4'hc, 0);
		chk("unmapped", 0, q);
		en <= 1'b1;
		pull <= 1'b1;
		cyc(30);
		chk("force", 1, frc);
		chk("drv_on", 0, den);
		bus(1, CONTROL_ADDR, 32'h1);
		bus(0, CONTROL_ADDR, 0);
		chk("ctl_forced", 32'h2, q);
		bus(0, STATUS_ADDR, 0);
		chk("status", 32'h8, q & 32'h9);
		cyc(70);
		chk("force", 0, frc);
		pull <= 1'b0;
		cyc(20);
		chk("force", 1, frc);
		bus(0, STATUS_ADDR, 0);
		chk("status", 32'h1, q & 32'h21);
		cyc(55);
		chk("force", 1, frc);
		cyc(80);
		chk("force", 0, frc);
		bus(1, CONTROL_ADDR, 32'h3);
		cyc(5);
		chk("force", 1, frc);
		bus(1, CONTROL_ADDR, 32'h2);
		cyc(30);
		chk("force", 1, frc);
		cyc(70);
		chk("force", 0, frc);
		len <= 16'h03e8;
		pull <= 1'b1;
		cyc(2);
		pull <= 1'b0;
		cyc(100);
		chk("force", 1, frc);
		fall <= 1'b1;
		cyc(130);
		chk("force", 0, frc);
		ow <= 1'b1;
		cyc(4);
		chk("force", 1, frc);
		end_of_test();
	end
endmodule : rg_reset_gen_tb_top
